// ==== verilog/ffa_pkg.sv ====
package ffa_pkg;
   // ==========================================================
   // word and field geometry
   localparam int FRAC_W     = 64;  // internal fraction width
   localparam int OVF_BIT    = 63;  // fraction overflow position
   localparam int HID_BIT    = 62;  // hidden bit position
   localparam int EXP_W      = 8;   // stored exponent width
   localparam int SGL_W      = 32;  // single floating word
   localparam int DBL_W      = 64;  // double floating word
   localparam int SGL_FRAC_W = 23;  // stored single fraction
   localparam int DBL_FRAC_W = 55;  // stored double fraction
   localparam int SHORT_W    = 16;  // short integer
   localparam int LONG_W     = 32;  // long integer
   localparam int XE_W       = 10;  // working exponent, signed

   // ==========================================================
   // exponent constants (excess 200 octal)
   localparam logic signed [XE_W-1:0] EXP_BIAS = 10'sh080;
   localparam logic signed [XE_W-1:0] EXP_MAX  = 10'sh0FF;
   // integer magnitude sits at 2^-32 weight, so true exp is 32
   localparam logic signed [XE_W-1:0] ITOF_EXP = 10'sh0A0;
   localparam logic signed [XE_W-1:0] SHORT_TE = 10'sh00F;
   localparam logic signed [XE_W-1:0] LONG_TE  = 10'sh01F;
   localparam logic [6:0]             DIV_LAST = 7'h3F;

   // ==========================================================
   // operations
   typedef enum logic [2:0] {
      OP_ADD  = 3'h0,
      OP_SUB  = 3'h1,
      OP_MUL  = 3'h2,
      OP_DIV  = 3'h3,
      OP_ITOF = 3'h4,
      OP_FTOI = 3'h5,
      OP_NEG  = 3'h6
   } ffa_op_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ALIGN = 4'b0010,
      ST_DIV   = 4'b0100,
      ST_NORM  = 4'b1000
   } ffa_st_t;

   typedef struct packed {
      ffa_op_t            op;
      logic [DBL_W-1:0]   a;
      logic [DBL_W-1:0]   b;
   } ffa_req_t;

   typedef struct packed {
      logic [DBL_W-1:0]   result;
      logic               conv_error;
      logic               div_zero;
      logic               exp_overflow;
   } ffa_rsp_t;

   typedef struct packed {
      logic                    sign;
      logic signed [XE_W-1:0]  exp;
      logic [FRAC_W-1:0]       frac;
   } ffa_unp_t;
endpackage

// ==== verilog/ffa_datapath.sv ====
`timescale 1ns/10ps
// Overview of operation
// - add/sub: shift smaller-exponent fraction right first
// - multiply: multiply fractions, add exponents
// - divide: divide fractions, subtract exponents
// - accept short, long, single, double operands only
// - returned words use one of four formats
// - short integer 16 bits, long 32 bits
// - integers are two's complement, msb sign
// - single floating 32 bits, double 64 bits
// - sign, 8-bit exponent, 23 or 55 fraction
// - sign-magnitude: negate flips only sign (code returns all zeros for a zero exponent)
// - normalize: bit 63 zero, bit 62 one
// - overflow bit set: shift right, exponent up
// - drop hidden bit out, insert one in
// - internal fields equal memory fields plus extras
// - exponent stored excess 200 octal
// - exponent code zero means value zero
// - left shift until leading one, exponent down
// - double select picks 64-bit floating format
// - long select picks 32-bit integers
module ffa_datapath
   import ffa_pkg::*;
(
   input  wire logic             clock,         // 50 MHz clock
   input  wire logic             reset_n,       // async reset, low
   input  wire logic             start,         // take request
   input  wire ffa_pkg::ffa_req_t req,          // op and operands
   input  wire logic             double_precision_select, // mode
   input  wire logic             long_integer_select,     // mode
   output logic                  busy,          // operation running
   output logic                  done,          // result valid pulse
   output ffa_pkg::ffa_rsp_t     rsp            // result and flags
);
   import ffa_pkg::*;

   // ==========================================================
   // state record
   typedef struct packed {
      ffa_st_t                 st;
      ffa_op_t                 op;
      logic                    dp;
      logic                    li;
      logic                    sa;
      logic                    sb;
      logic signed [XE_W-1:0]  ea;
      logic signed [XE_W-1:0]  eb;
      logic [FRAC_W-1:0]       fa;
      logic [FRAC_W-1:0]       fb;
      logic [FRAC_W:0]         rem;
      logic [6:0]              cnt;
      logic                    busy;
      logic                    done;
      ffa_rsp_t                rsp;
   } ffa_state_t;

   ffa_state_t r_q;
   ffa_state_t r_d;

   // ==========================================================
   // format helpers
   // memory word to internal form; zero code forces clean zero
   function automatic ffa_unp_t unpack(input logic [DBL_W-1:0] w,
                                       input logic dp);
      ffa_unp_t u;
      u.sign = 1'b0;
      u.exp  = '0;
      u.frac = '0;
      if (dp) begin
         u.sign = w[DBL_W-1];
         u.exp  = XE_W'(w[DBL_W-2 -: EXP_W]);
         u.frac = {2'b01, w[DBL_FRAC_W-1:0], 7'h00};
      end else begin
         u.sign = w[SGL_W-1];
         u.exp  = XE_W'(w[SGL_W-2 -: EXP_W]);
         u.frac = {2'b01, w[SGL_FRAC_W-1:0], 39'h00};
      end
      // minus zero is read as plain zero too
      if (u.exp == '0) begin
         u.sign = 1'b0;
         u.frac = '0;
      end
      return u;
   endfunction

   // internal form to memory word, hidden bit dropped
   function automatic logic [DBL_W-1:0] pack(
         input logic s, input logic [EXP_W-1:0] e,
         input logic [FRAC_W-1:0] f, input logic dp);
      if (e == '0) begin
         pack = '0;
      end else if (dp) begin
         pack = {s, e, f[HID_BIT-1 -: DBL_FRAC_W]};
      end else begin
         pack = {32'h0, s, e, f[HID_BIT-1 -: SGL_FRAC_W]};
      end
   endfunction

   // ==========================================================
   // combinational operand views
   ffa_unp_t                 ua;
   ffa_unp_t                 ub;
   logic [2*HID_BIT+1:0]     prod;
   logic [LONG_W-1:0]        iraw;
   logic [LONG_W-1:0]        imag;
   logic signed [XE_W-1:0]   te;
   logic signed [XE_W-1:0]   tlim;
   logic [FRAC_W-1:0]        fmag;
   logic [LONG_W-1:0]        ival;
   logic                     sbe;

   always_comb begin
      ua   = unpack(req.a, double_precision_select);
      ub   = unpack(req.b, double_precision_select);
      prod = r_q.fa[HID_BIT:0] * r_q.fb[HID_BIT:0];
      // integer in: sign-extend short to long width
      if (long_integer_select) begin
         iraw = req.a[LONG_W-1:0];
      end else begin
         iraw = {{(LONG_W-SHORT_W){req.a[SHORT_W-1]}},
                 req.a[SHORT_W-1:0]};
      end
      imag = iraw[LONG_W-1] ? (~iraw + 32'h1) : iraw;
      // floating to integer: truncating shift of magnitude
      te   = ua.exp - EXP_BIAS;
      tlim = long_integer_select ? LONG_TE : SHORT_TE;
      fmag = ua.frac >> (6'(OVF_BIT) - te[5:0]);
      ival = ua.sign ? (~fmag[LONG_W-1:0] + 32'h1)
                     : fmag[LONG_W-1:0];
      // effective sign of the second operand
      sbe  = r_q.sb ^ (r_q.op == OP_SUB);
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;
      unique case (r_q.st)
         ST_IDLE: begin
            if (start) begin
               r_d.op   = req.op;
               r_d.dp   = double_precision_select;
               r_d.li   = long_integer_select;
               r_d.sa   = ua.sign;
               r_d.sb   = ub.sign;
               r_d.ea   = ua.exp;
               r_d.eb   = ub.exp;
               r_d.fa   = ua.frac;
               r_d.fb   = ub.frac;
               r_d.rsp  = '0;
               r_d.busy = 1'b1;
               unique case (req.op)
                  OP_ADD, OP_SUB: r_d.st = ST_ALIGN;
                  OP_MUL: begin
                     r_d.sa = ua.sign ^ ub.sign;
                     // product wants a cycle of registered inputs
                     r_d.ea = ua.exp + ub.exp - EXP_BIAS;
                     r_d.st = ST_DIV;
                     r_d.cnt = '0;
                  end
                  OP_DIV: begin
                     r_d.sa  = ua.sign ^ ub.sign;
                     r_d.ea  = ua.exp - ub.exp + EXP_BIAS;
                     r_d.rem = {1'b0, ua.frac};
                     r_d.fa  = '0;
                     r_d.cnt = DIV_LAST;
                     r_d.st  = ST_DIV;
                     if (ub.frac == '0) begin
                        r_d.rsp.div_zero = 1'b1;
                        r_d.rsp.result   = '0;
                        r_d.busy = 1'b0;
                        r_d.done = 1'b1;
                        r_d.st   = ST_IDLE;
                     end
                  end
                  OP_ITOF: begin
                     r_d.sa = iraw[LONG_W-1];
                     r_d.ea = ITOF_EXP;
                     r_d.fa = {1'b0, imag, 31'h0};
                     r_d.st = ST_NORM;
                  end
                  OP_FTOI: begin
                     // error clears the destination
                     r_d.rsp.result = '0;
                     if (ua.exp != '0 && te > 0) begin
                        if (te > tlim) begin
                           r_d.rsp.conv_error = 1'b1;
                        end else if (long_integer_select) begin
                           r_d.rsp.result = {32'h0, ival};
                        end else begin
                           r_d.rsp.result =
                              {48'h0, ival[SHORT_W-1:0]};
                        end
                     end
                     r_d.busy = 1'b0;
                     r_d.done = 1'b1;
                  end
                  OP_NEG: begin
                     // only the sign moves; a zero exponent gives a clean zero
                     r_d.rsp.result = pack(~ua.sign, ua.exp[7:0],
                                           ua.frac,
                                           double_precision_select);
                     r_d.busy = 1'b0;
                     r_d.done = 1'b1;
                  end
                  default: begin
                     r_d.busy = 1'b0;
                     r_d.done = 1'b1;
                  end
               endcase
            end
         end
         ST_ALIGN: begin
            // one shift per cycle; a zero operand jumps at once
            if (r_q.ea < r_q.eb) begin
               if (r_q.fa == '0) begin
                  r_d.ea = r_q.eb;
               end else begin
                  r_d.fa = r_q.fa >> 1;
                  r_d.ea = r_q.ea + 10'sh001;
               end
            end else if (r_q.eb < r_q.ea) begin
               if (r_q.fb == '0) begin
                  r_d.eb = r_q.ea;
               end else begin
                  r_d.fb = r_q.fb >> 1;
                  r_d.eb = r_q.eb + 10'sh001;
               end
            end else begin
               // sign-magnitude sum of aligned fractions
               if (r_q.sa == sbe) begin
                  r_d.fa = r_q.fa + r_q.fb;
               end else if (r_q.fa >= r_q.fb) begin
                  r_d.fa = r_q.fa - r_q.fb;
               end else begin
                  r_d.fa = r_q.fb - r_q.fa;
                  r_d.sa = sbe;
               end
               r_d.st = ST_NORM;
            end
         end
         ST_DIV: begin
            if (r_q.op == OP_MUL) begin
               // top product bits keep the 2^-63 weighting
               r_d.fa = {1'b0, prod[2*HID_BIT+1 -: OVF_BIT]};
               r_d.st = ST_NORM;
            end else begin
               // restoring divide, one quotient bit a cycle
               if (r_q.rem >= {1'b0, r_q.fb}) begin
                  r_d.rem = (r_q.rem - {1'b0, r_q.fb}) << 1;
                  r_d.fa  = r_q.fa | (64'h1 << r_q.cnt[5:0]);
               end else begin
                  r_d.rem = r_q.rem << 1;
               end
               r_d.cnt = r_q.cnt - 7'h01;
               if (r_q.cnt == '0) begin
                  r_d.st = ST_NORM;
               end
            end
         end
         ST_NORM: begin
            if (r_q.fa == '0) begin
               r_d.rsp.result = '0;
               r_d.busy = 1'b0;
               r_d.done = 1'b1;
               r_d.st   = ST_IDLE;
            end else if (r_q.fa[OVF_BIT]) begin
               r_d.fa = r_q.fa >> 1;
               r_d.ea = r_q.ea + 10'sh001;
            end else if (!r_q.fa[HID_BIT]) begin
               r_d.fa = r_q.fa << 1;
               r_d.ea = r_q.ea - 10'sh001;
            end else begin
               // normalized: bit 63 clear, bit 62 set
               if (r_q.ea <= 0) begin
                  // underflow delivers a clean zero
                  r_d.rsp.result = '0;
               end else begin
                  // overflow keeps the exponent off by 400 octal
                  r_d.rsp.exp_overflow = (r_q.ea > EXP_MAX);
                  r_d.rsp.result = pack(r_q.sa, r_q.ea[7:0],
                                        r_q.fa, r_q.dp);
               end
               r_d.busy = 1'b0;
               r_d.done = 1'b1;
               r_d.st   = ST_IDLE;
            end
         end
         default: begin
            r_d.st   = ST_IDLE;
            r_d.busy = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         r_q    <= '0;
         r_q.st <= ST_IDLE;
         r_q.op <= OP_ADD;
      end else begin
         r_q <= r_d;
      end
   end

   // outputs straight from the state record
   assign busy = r_q.busy;
   assign done = r_q.done;
   assign rsp  = r_q.rsp;
endmodule

// ==== dv/ffa_checker.sv ====
`timescale 1ns/10ps
// ==========================================================
// checker on the datapath ports
module ffa_checker
   import ffa_pkg::*;
(
   input wire logic              clock,                   // clock
   input wire logic              reset_n,                 // reset, low
   input wire logic              start,                   // strobe
   input wire ffa_pkg::ffa_req_t req,                     // request
   input wire logic              double_precision_select, // mode
   input wire logic              long_integer_select,     // mode
   input wire logic              busy,                    // running
   input wire logic              done,                    // pulse
   input wire ffa_pkg::ffa_rsp_t rsp                      // result
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic    take, bz, dp_q, li_q, zexp;
   ffa_op_t op_q;
   // a start only counts while idle
   assign take = start && !busy;
   assign bz   = double_precision_select ? req.b[62:55] == 8'h00
                                         : req.b[30:23] == 8'h00;
   assign zexp = dp_q ? rsp.result[62:55] == 8'h00
                      : rsp.result[30:23] == 8'h00;
   // modes kept from the taking edge, done refers back to them
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dp_q <= 1'b0;
         li_q <= 1'b0;
         op_q <= OP_ADD;
      end else if (take) begin
         dp_q <= double_precision_select;
         li_q <= long_integer_select;
         op_q <= req.op;
      end
   end
   property p_ftoi_lat;
      take && req.op == OP_FTOI |=> done && !busy;
   endproperty
   a_ftoi_lat: assert property (p_ftoi_lat)
      else $error("conversion not answered next cycle");
   property p_neg_dbl;
      take && req.op == OP_NEG && double_precision_select
      && req.a[62:55] != 8'h00 |=> done && rsp.result ==
      {~$past(req.a[63]), $past(req.a[62:0])};
   endproperty
   a_neg_dbl: assert property (p_neg_dbl)
      else $error("double negate changed magnitude");
   property p_neg_sgl;
      take && req.op == OP_NEG && !double_precision_select
      && req.a[30:23] != 8'h00 |=> done && rsp.result ==
      {32'h0, ~$past(req.a[31]), $past(req.a[30:0])};
   endproperty
   a_neg_sgl: assert property (p_neg_sgl)
      else $error("single negate wrong");
   property p_div_zero;
      take && req.op == OP_DIV && bz
      |=> done && rsp.div_zero && rsp.result == 64'h0;
   endproperty
   a_div_zero: assert property (p_div_zero)
      else $error("zero divisor not flagged");
   property p_sgl_upper;
      done && !dp_q && op_q != OP_FTOI |-> rsp.result[63:32] == 32'h0;
   endproperty
   a_sgl_upper: assert property (p_sgl_upper)
      else $error("single result upper half not zero");
   property p_zero_canon;
      done && op_q != OP_FTOI && zexp |-> rsp.result == 64'h0;
   endproperty
   a_zero_canon: assert property (p_zero_canon)
      else $error("zero result not canonical");
   property p_mul_lat;
      take && req.op == OP_MUL |-> ##[1:6] done;
   endproperty
   a_mul_lat: assert property (p_mul_lat)
      else $error("multiply took too long");
   property p_ill_op;
      take && req.op == 3'h7 |=> done && rsp.result == 64'h0;
   endproperty
   a_ill_op: assert property (p_ill_op)
      else $error("unknown op not answered with zero");
   property p_short_int;
      done && op_q == OP_FTOI && !li_q |-> rsp.result[63:16] == 48'h0;
   endproperty
   a_short_int: assert property (p_short_int)
      else $error("short integer wider than 16 bits");
   c_add: cover property (take && req.op == OP_ADD ##[1:300] done);
   c_div: cover property (take && req.op == OP_DIV && !bz);
   c_ftoi: cover property (take && req.op == OP_FTOI);
endmodule

bind ffa_datapath ffa_checker ffa_checker_i (.*);

// ==== dv/ffa_host.sv ====
`timescale 1ns/10ps
// ==========================================================
// host model: issues one instruction at a time
module ffa_host
   import ffa_pkg::*;
(
   input  wire logic              clock,   // clock
   input  wire logic              busy,    // datapath running
   input  wire logic              done,    // result pulse
   input  wire ffa_pkg::ffa_rsp_t rsp,     // result
   output logic                   start,   // strobe
   output ffa_pkg::ffa_req_t      req,     // request
   output logic                   dps,     // double select
   output logic                   lis      // long select
);
   initial begin
      start = 1'b0;
      req   = '0;
      dps   = 1'b0;
      lis   = 1'b0;
   end
   // hold the request until an idle edge takes it, then scramble
   // the released lines so stale operands cannot pass by luck
   task automatic run(input ffa_op_t op, input logic [63:0] a,
                      input logic [63:0] b, input logic dp,
                      input logic li, output ffa_rsp_t r);
      int n;
      @(posedge clock);
      #1;
      start = 1'b1;
      req   = '{op, a, b};
      dps   = dp;
      lis   = li;
      // busy and done move only on rising edges, so the falling edge
      // shows what the next rising edge sees, free of any race
      n     = 0;
      do begin
         @(negedge clock);
         n++;
      end while (busy !== 1'b0 && n < 500);
      @(posedge clock);
      #1;
      start = 1'b0;
      req   = ffa_req_t'(~req);
      dps   = ~dp;
      lis   = ~li;
      n     = 0;
      do begin
         @(negedge clock);
         n++;
      end while (done !== 1'b1 && n < 500);
      r = rsp;
      // a missing answer must never compare equal by luck
      if (done !== 1'b1) begin
         r = 'x;
      end
   endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
// ==========================================================
// testbench top
module tb;
   import ffa_pkg::*;
   logic     clock, reset_n, start, dps, lis, busy, done;
   ffa_req_t req;
   ffa_rsp_t rsp, r;
   int       fails, total_checks;
   initial clock = 1'b0;
   always #10 clock = ~clock;
   ffa_datapath ffa_datapath_i (.clock(clock), .reset_n(reset_n),
      .start(start), .req(req), .double_precision_select(dps),
      .long_integer_select(lis), .busy(busy), .done(done),
      .rsp(rsp));
   ffa_host ffa_host_i (.clock(clock), .busy(busy), .done(done),
      .rsp(rsp), .start(start), .req(req), .dps(dps), .lis(lis));
   // ==========================================================
   // comparison and verdict
   task automatic check(input string nm, input logic [63:0] seen,
                        input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one instruction through the host, result against expectation
   task automatic go(input string nm, input ffa_op_t op,
                     input logic [63:0] a, input logic [63:0] b,
                     input logic dp, input logic li,
                     input logic [63:0] exp);
      ffa_host_i.run(op, a, b, dp, li, r);
      check(nm, r.result, exp);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_itof;
      go("itof75", OP_ITOF, 64'h4B, 64'h0, 1'b0, 1'b0, 64'h43960000);
      go("itofm5", OP_ITOF, 64'hFFFFFFFB, 64'h0, 1'b1, 1'b1,
         64'hC1A0000000000000);
      $display("done itof");
   endtask
   task automatic t_add;
      go("add", OP_ADD, 64'h43200000, 64'h41E00000, 1'b0, 1'b0,
         64'h433C0000);
      go("addovf", OP_ADD, 64'h40000000, 64'h40000000, 1'b0, 1'b0,
         64'h40800000);
      go("sub", OP_SUB, 64'h433C0000, 64'h43200000, 1'b0, 1'b0,
         64'h41E00000);
      $display("done add");
   endtask
   task automatic t_mul;
      go("mul", OP_MUL, 64'h41E00000, 64'h43200000, 1'b0, 1'b0,
         64'h448C0000);
      check("mulflag", {63'h0, r.exp_overflow}, 64'h0);
      go("mulz", OP_MUL, 64'h0, 64'h43200000, 1'b0, 1'b0, 64'h0);
      go("mulovf", OP_MUL, 64'h7F800000, 64'h7F800000, 1'b0, 1'b0,
         64'h3E800000);
      check("ovfflag", {63'h0, r.exp_overflow}, 64'h1);
      $display("done mul");
   endtask
   task automatic t_div;
      go("div", OP_DIV, 64'h4270000000000000, 64'h41A0000000000000,
         1'b1, 1'b0, 64'h4140000000000000);
      go("divz", OP_DIV, 64'h43200000, 64'h0, 1'b0, 1'b0, 64'h0);
      check("divzflag", {63'h0, r.div_zero}, 64'h1);
      go("divunf", OP_DIV, 64'h00800000, 64'h7F800000, 1'b0, 1'b0,
         64'h0);
      $display("done div");
   endtask
   task automatic t_neg;
      go("neg", OP_NEG, 64'h43200000, 64'h0, 1'b0, 1'b0, 64'hC3200000);
      go("negd", OP_NEG, 64'h4140000000000000, 64'h0, 1'b1, 1'b0,
         64'hC140000000000000);
      go("negz", OP_NEG, 64'h807FFFFF, 64'h0, 1'b0, 1'b0, 64'h0);
      go("ill", ffa_op_t'(3'h7), 64'h1, 64'h1, 1'b0, 1'b0, 64'h0);
      $display("done neg");
   endtask
   task automatic t_ftoi;
      go("ftoil", OP_FTOI, 64'h433C0000, 64'h0, 1'b0, 1'b1, 64'h2F);
      go("ftoim40", OP_FTOI, 64'hC3200000, 64'h0, 1'b0, 1'b1,
         64'hFFFFFFD8);
      go("ftois", OP_FTOI, 64'hC1A00000, 64'h0, 1'b0, 1'b0, 64'hFFFB);
      check("ftoisok", {63'h0, r.conv_error}, 64'h0);
      go("ftoierr", OP_FTOI, 64'h48000000, 64'h0, 1'b0, 1'b0, 64'h0);
      check("ftoiflag", {63'h0, r.conv_error}, 64'h1);
      $display("done ftoi");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      fails        = 0;
      total_checks = 0;
      reset_n      = 1'b0;
      repeat (10) @(posedge clock);
      #1 reset_n = 1'b1;
      t_itof();
      t_add();
      t_mul();
      t_div();
      t_neg();
      t_ftoi();
      print_verdict();
   end
   // whole run is a few hundred cycles; far beyond means a hang
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
endmodule
